// *** dv/ismon_src.sv ***
// clock source model for the four inputs and the reference pins
`timescale 1ns/1ps
module ismon_src (
  // clock, reset and stop controls
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [4:0] stop,
  // clocks, bit 4 is the reference
  output logic      [4:0] clk
);
  // half rate clocks that stand still while stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) clk <= 5'h00;
    else clk <= clk ^ ~stop;
  end
endmodule

// *** dv/ismon_sva.sv ***
// assertion checker for the input select and fault monitor
`timescale 1ns/1ps
module ismon_sva
  import ismon_pkg::*;
(
  // clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // status pins
  input wire logic        tracking,
  input wire logic        holdover,
  input wire logic        unlocked_flag_pin,
  input wire logic        interrupt_pin,
  input wire logic        hitless_absorb,
  input wire logic        pull_in
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;
  logic [2:0] since_r;
  assign take = hsel && htrans[1] && hready;
  // cycles since a sticky or mask write was taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) since_r <= 3'h7;
    else if (take && hwrite && (haddr == OFS_STICKY || haddr == OFS_MASK)) since_r <= 3'h0;
    else if (since_r != 3'h7) since_r <= since_r + 3'h1;
  end
  // holdover is only entered straight from tracking
  property p_modes;
    !(holdover && tracking) && (!$rose(holdover) || $fell(tracking));
  endproperty
  a_modes: assert property (p_modes) else $error("holdover with tracking");
  property p_unl_drop; $fell(tracking) |-> ##[0:3] unlocked_flag_pin; endproperty
  a_unl_drop: assert property (p_unl_drop) else $error("no unlock on drop");
  property p_pull_unl; pull_in |-> ##[0:3] unlocked_flag_pin; endproperty
  a_pull_unl: assert property (p_pull_unl) else $error("pull-in while locked");
  property p_pulse_excl; !(pull_in && hitless_absorb); endproperty
  a_pulse_excl: assert property (p_pulse_excl) else $error("both switch pulses");
  property p_pull_one; pull_in |=> !pull_in; endproperty
  a_pull_one: assert property (p_pull_one) else $error("pull-in pulse too long");
  property p_irq_drop; $fell(interrupt_pin) |-> since_r < 3'h6; endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt dropped alone");
  property p_wr_wait; take && hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait state wrong");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
endmodule
bind ismon_core ismon_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .tracking, .holdover, .unlocked_flag_pin, .interrupt_pin,
  .hitless_absorb, .pull_in);

// *** dv/tb_top.sv ***
// self-checking bench for the input select and fault monitor
`timescale 1ns/1ps
module tb_top;
  import ismon_pkg::*;
  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic             tracking, holdover, unl, irq, oen;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans, pins, act;
  logic [2:0]       hsize;
  logic [LOL_W-1:0] diff;
  logic [4:0]       stop, clk;
  logic [3:0]       pat[$];
  int               error_cnt, check_count, cyc, cur, um, d;
  int               prio[4];
  logic [31:0]      ra[10] = '{OFS_CTRL, OFS_PRIO, OFS_SENS, OFS_OOF, OFS_LOL_SET,
                              OFS_LOL_CLR, OFS_LOL_DLY, OFS_MASK, OFS_MONDIS, 32'h40};
  logic [31:0]      rv[10] = '{32'h60, 32'hE4, 32'h01010101, 32'h103, 32'hA, 32'h1,
                              32'h0, 32'h3FFFF, 32'h0, 32'h0};
  // design and far-side clock sources
  ismon_core #(.GATE(64)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .clock_input_0(clk[0]),
    .clock_input_1(clk[1]), .clock_input_2(clk[2]), .clock_input_3(clk[3]),
    .ref_osc_pins(clk[4]), .input_sel_pins(pins), .pd_freq_diff(diff), .active_input(act),
    .tracking, .holdover, .unlocked_flag_pin(unl), .interrupt_pin(irq),
    .outputs_enable(oen), .hitless_absorb(), .pull_in());
  ismon_src u_src (.hclk, .hresetn, .stop, .clk);
  // clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // hang limit
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // single ahb transfer, read data left in rd
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] dat);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task w(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // model of automatic choice, ties to the lower index
  function int pick(input logic [3:0] ok, input int c, input int rev);
    int best;
    best = -1;
    if (rev == 0 && c >= 0 && ok[c]) return c;
    for (int i = 3; i >= 0; i--) if (ok[i] && (best < 0 || prio[i] <= prio[best])) best = i;
    return best;
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, pins, diff, stop} = '0;
    hsize = 3'h2;
    d = $urandom(26257);
    w(2);
    hresetn <= 1'b1;
    w(1);
    bus(1, 32'h40, 32'hFFFF_FFFF);
    foreach (ra[i]) begin
      bus(0, ra[i], 0);
      chk("reg", rd, rv[i]);
    end
    $display("reset values done");
    bus(1, OFS_CTRL, 32'h860);
    repeat (6) begin
      d = $urandom_range(3, 0);
      pins <= 2'(d);
      w(8);
      chk("pin sel", {tracking, act}, {1'b1, 2'(d)});
    end
    pins <= 2'h3;
    bus(1, OFS_CTRL, 32'h868);
    w(8);
    chk("zero delay", tracking, 0);
    bus(1, OFS_CTRL, 32'h865);
    w(8);
    chk("reg sel", act, 2);
    stop <= 5'h04;
    w(80);
    chk("fallback", holdover, 1);
    bus(1, OFS_STICKY, 32'h4);
    bus(0, OFS_STICKY, 0);
    chk("sticky", rd[2], 1);
    bus(0, OFS_LIVE, 0);
    chk("live", rd[3:0], 4'h4);
    bus(1, OFS_MONDIS, 32'h4);
    w(300);
    bus(0, OFS_LIVE, 0);
    chk("absent off", rd[3:0], 0);
    chk("excursion", rd[11:8], 4'h4);
    bus(1, OFS_CTRL, 32'h1865);
    w(4);
    bus(0, OFS_LIVE, 0);
    chk("precise off", rd[11:8], 0);
    bus(1, OFS_CTRL, 32'h865);
    bus(1, OFS_MONDIS, 0);
    stop <= 5'h00;
    w(400);
    $display("manual select done");
    d = $urandom_range(255, 0);
    bus(1, OFS_PRIO, d);
    for (int k = 0; k < 4; k++) prio[k] = (d >> (2 * k)) & 3;
    pat = '{4'h0, 4'h1, 4'h3, 4'h0, 4'h6, 4'hF, 4'h0};
    for (int r = 1; r >= 0; r--) begin
      bus(1, OFS_CTRL, r ? 32'h870 : 32'h850);
      cur = -1;
      foreach (pat[i]) begin
        stop <= {1'b0, pat[i]};
        w(500);
        cur = pick(~pat[i], cur, r);
        if (cur < 0) chk("auto hold", holdover, 1);
        else chk("auto", {holdover, act}, cur);
      end
    end
    $display("auto select done");
    um = 0;
    for (int k = 0; k < 12; k++) begin
      d = $urandom_range(20, 0);
      diff <= 17'(d);
      w(4);
      um = d > 10 ? 1 : d < 1 ? 0 : um;
      chk("unlocked", unl, um);
    end
    bus(1, OFS_LOL_DLY, 32'd20);
    diff <= 17'd15;
    w(4);
    diff <= 17'd0;
    w(10);
    chk("delay hold", unl, 1);
    w(20);
    chk("delay clear", unl, 0);
    bus(1, OFS_MASK, 32'h2FFFF);
    w(4);
    chk("irq", irq, 1);
    bus(1, OFS_STICKY, 32'h10000);
    w(4);
    chk("irq clear", irq, 0);
    $display("lock and interrupt done");
    stop <= 5'h10;
    w(80);
    chk("outputs off", oen, 0);
    bus(1, OFS_CTRL, 32'h8F0);
    w(4);
    chk("outputs kept", oen, 1);
    $display("reference loss done");
    finish_test();
  end
endmodule

// *** hdl/ismon_clk_mon.sv ***
// missing-edge and frequency excursion monitor for one sampled clock
`timescale 1ns/1ps
module ismon_clk_mon
  import ismon_pkg::*;
#(
  parameter int unsigned GATE     = GATE_DEF,
  parameter int unsigned FAST_CNT = 2000
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // monitored clock and reference tick
  input  wire logic             sig,
  input  wire logic             ref_tick,
  // configuration
  input  wire logic             absent_dis,
  input  wire logic             precise_dis,
  input  wire logic             fast_dis,
  input  wire logic [LIM_W-1:0] limit,
  input  wire logic [7:0]       win,
  input  wire logic [7:0]       hyst,
  // status
  output logic                  absent_r,
  output logic                  excursion_r
);
  logic             sig_d_r;
  logic [LIM_W-1:0] gap_r;
  logic [CNT_W-1:0] gate_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] prev_r;
  logic             have_prev_r;
  logic             precise_r;
  logic             fast_r;
  logic             edge_w;
  logic [CNT_W-1:0] meas_w;
  logic [CNT_W-1:0] dev_w;
  logic             gate_end_w;

  function automatic logic [CNT_W-1:0] absdiff(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  assign edge_w     = sig & ~sig_d_r;
  assign gate_end_w = ref_tick && (gate_r == CNT_W'(GATE - 1));
  assign meas_w     = cnt_r + CNT_W'(edge_w);
  assign dev_w      = absdiff(meas_w, CNT_W'(GATE));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_d_r  <= 1'b0;
      gap_r    <= '0;
      absent_r <= 1'b0;
    end else begin
      sig_d_r <= sig;
      if (edge_w) begin
        gap_r <= '0;
      end else if (gap_r != '1) begin
        gap_r <= gap_r + 1'b1;
      end
      absent_r <= !absent_dis && (gap_r >= limit);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_r      <= '0;
      cnt_r       <= '0;
      prev_r      <= '0;
      have_prev_r <= 1'b0;
      precise_r   <= 1'b0;
      fast_r      <= 1'b0;
    end else if (gate_end_w) begin
      gate_r      <= '0;
      cnt_r       <= '0;
      prev_r      <= meas_w;
      have_prev_r <= 1'b1;
      if (dev_w > CNT_W'(win)) begin
        precise_r <= 1'b1;
      end else if ((dev_w + CNT_W'(hyst)) <= CNT_W'(win)) begin
        precise_r <= 1'b0;
      end
      fast_r <= have_prev_r && (absdiff(meas_w, prev_r) > CNT_W'(FAST_CNT));
    end else begin
      gate_r <= gate_r + CNT_W'(ref_tick);
      if (edge_w && cnt_r != '1) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      excursion_r <= 1'b0;
    end else begin
      excursion_r <= (precise_r & ~precise_dis) | (fast_r & ~fast_dis);
    end
  end
endmodule

// *** hdl/ismon_core.sv ***
// input clock selection, fault monitoring and status registers
//
// Summary of operation
// - a control bit picks pin or register selection; pins rule after reset.
// - codes 0..3 pick inputs 0..3; zero delay makes code 3 reserved.
// - manual choice with no clock falls back to free-run or holdover.
// - automatic mode picks only valid inputs; none valid means free-run or holdover.
// - revertive mode always tracks the best valid input, switching back at once.
// - non-revertive mode keeps the active input until it becomes invalid.
// - hitless switch absorbs phase when both inputs are frequency locked.
// - switching with pull-in raises unlocked; no runt pulses are produced.
// - gapped clocks of limited missing cycles raise no fault flags.
// - four inputs get absent and excursion monitors; reference pins absent only.
// - absent monitor checks each period; sensitivity and disable per input.
// - every condition has a live bit and a sticky bit.
// - outputs disable on reference absence unless configured to keep running.
// - excursion reference is the reference pins or any one input.
// - excursion status combines precise and fast monitors, each disableable.
// - precise monitor flags outside a programmable window with hysteresis.
// - fast monitor flags a frequency step above 4000 ppm.
// - lock loss uses separate set and clear thresholds at the detector.
// - a pin mirrors the live unlocked state.
// - an optional timer delays clearing of unlocked.
// - interrupt pin asserts on any unmasked status event; one mask each.
// - interrupt pin drops only when the causing sticky bit is cleared or masked.
`timescale 1ns/1ps
module ismon_core
  import ismon_pkg::*;
#(
  parameter int unsigned GATE = GATE_DEF
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // monitored clocks
  input  wire logic             clock_input_0,
  input  wire logic             clock_input_1,
  input  wire logic             clock_input_2,
  input  wire logic             clock_input_3,
  input  wire logic             ref_osc_pins,
  // select pins and loop feedback
  input  wire logic [1:0]       input_sel_pins,
  input  wire logic [LOL_W-1:0] pd_freq_diff,
  // status pins
  output logic [1:0]            active_input,
  output logic                  tracking,
  output logic                  holdover,
  output logic                  unlocked_flag_pin,
  output logic                  interrupt_pin,
  output logic                  outputs_enable,
  output logic                  hitless_absorb,
  output logic                  pull_in
);
  localparam longint unsigned FAST_L = FAST_PPM * longint'(GATE) / PPM_SCALE;
  localparam int unsigned FAST_CNT = int'(FAST_L);

  // configuration registers
  ismon_ctrl_t       ctrl_r;
  logic [7:0]        prio_r;
  logic [31:0]       sens_r;
  logic [15:0]       oof_r;
  logic [LOL_W-1:0]  lol_set_r;
  logic [LOL_W-1:0]  lol_clr_r;
  logic [DLY_W-1:0]  lol_dly_r;
  logic [FLAG_W-1:0] mask_r;
  logic [4:0]        mondis_r;
  logic [FLAG_W-1:0] sticky_r;
  // bus data phase state
  logic              wr_pend_r;
  logic [31:0]       wr_addr_r;
  // clock sampling and monitors
  logic [4:0]        clk_d_r;
  logic              ref_tick_r;
  logic [3:0]        abs_v;
  logic [3:0]        exc_v;
  logic              ref_abs;
  logic              unlocked_w;
  logic [3:0]        valid_w;
  logic [4:0]        clk_v;
  // selector
  ismon_mode_t       mode_r;
  ismon_mode_t       mode_nxt;
  logic [1:0]        active_r;
  logic [1:0]        sel_nxt;
  logic [1:0]        man_code;
  logic [2:0]        best;
  logic              found;
  logic              switch_w;
  logic              hitless_ok;
  // status
  logic [FLAG_W-1:0] live_w;
  logic [FLAG_W-1:0] w1c_w;
  logic [FLAG_W-1:0] sticky_nxt;
  logic              addr_ph;
  logic              wr_do;

  function automatic logic [2:0] pick_best(input logic [3:0] v, input logic [7:0] p);
    logic       f;
    logic [1:0] idx;
    logic [1:0] bp;
    f   = 1'b0;
    idx = 2'b00;
    bp  = 2'b11;
    for (int i = 0; i < 4; i++) begin
      if (v[i] && (!f || p[2*i +: 2] < bp)) begin
        f   = 1'b1;
        idx = 2'(i);
        bp  = p[2*i +: 2];
      end
    end
    pick_best = {f, idx};
  endfunction

  assign clk_v   = {ref_osc_pins, clock_input_3, clock_input_2,
                    clock_input_1, clock_input_0};
  assign addr_ph = hsel && htrans[1] && hready;
  assign wr_do   = wr_pend_r;

  // edge of the chosen zero-ppm reference
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_d_r    <= 5'h00;
      ref_tick_r <= 1'b0;
    end else begin
      clk_d_r <= clk_v;
      if (ctrl_r.oof_ref == 3'h0) begin
        ref_tick_r <= clk_v[4] & ~clk_d_r[4];
      end else if (ctrl_r.oof_ref <= 3'h4) begin
        ref_tick_r <= clk_v[ctrl_r.oof_ref - 3'h1] & ~clk_d_r[ctrl_r.oof_ref - 3'h1];
      end else begin
        ref_tick_r <= 1'b0;
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_mon
    ismon_clk_mon #(
      .GATE     (GATE),
      .FAST_CNT (FAST_CNT)
    ) u_mon (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .sig         (clk_v[g]),
      .ref_tick    (ref_tick_r),
      .absent_dis  (mondis_r[g]),
      .precise_dis (ctrl_r.prec_dis),
      .fast_dis    (ctrl_r.fast_dis),
      .limit       ({sens_r[8*g +: 8], 6'h00}),
      .win         (oof_r[7:0]),
      .hyst        (oof_r[15:8]),
      .absent_r    (abs_v[g]),
      .excursion_r (exc_v[g])
    );
  end

  ismon_clk_mon #(
    .GATE     (GATE),
    .FAST_CNT (FAST_CNT)
  ) u_ref_mon (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .sig         (clk_v[4]),
    .ref_tick    (1'b0),
    .absent_dis  (mondis_r[4]),
    .precise_dis (1'b1),
    .fast_dis    (1'b1),
    .limit       (REF_ABS_LIMIT),
    .win         (8'h00),
    .hyst        (8'h00),
    .absent_r    (ref_abs),
    .excursion_r ()
  );

  // lock detector
  ismon_lock_mon u_lock (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .pd_diff      (pd_freq_diff),
    .set_thr      (lol_set_r),
    .clr_thr      (lol_clr_r),
    .dly          (lol_dly_r),
    .force_unlock (pull_in || mode_r != MODE_TRACK),
    .unlocked_r   (unlocked_w)
  );

  // qualified inputs; input 3 is feedback in zero delay
  assign valid_w = ~abs_v & ~exc_v & {~ctrl_r.zero_delay, 3'b111};

  // selection decision and mode transitions
  always_comb begin
    man_code = ctrl_r.reg_sel_en ? ctrl_r.reg_sel : input_sel_pins;
    best     = pick_best(valid_w, prio_r);
    sel_nxt  = active_r;
    found    = 1'b0;
    if (!ctrl_r.auto_en) begin
      // code 3 reserved in zero delay
      // manual input with no clock falls back
      found   = !abs_v[man_code] && !(ctrl_r.zero_delay && man_code == 2'b11);
      sel_nxt = man_code;
    end else if (ctrl_r.revertive) begin
      found   = best[2];
      sel_nxt = best[1:0];
    end else if (mode_r == MODE_TRACK && valid_w[active_r]) begin
      found   = 1'b1;
    end else begin
      found   = best[2];
      sel_nxt = best[1:0];
    end
    case (mode_r)
      MODE_FREERUN:  mode_nxt = found ? MODE_TRACK : MODE_FREERUN;
      MODE_TRACK:    mode_nxt = found ? MODE_TRACK : MODE_HOLDOVER;
      MODE_HOLDOVER: mode_nxt = found ? MODE_TRACK : MODE_HOLDOVER;
      default:       mode_nxt = MODE_FREERUN;
    endcase
    if (!found) begin
      sel_nxt = active_r;
    end
    switch_w   = (mode_nxt == MODE_TRACK) && (mode_r != MODE_TRACK || sel_nxt != active_r);
    hitless_ok = ctrl_r.hitless_en && !ctrl_r.zero_delay && mode_r == MODE_TRACK &&
                 !exc_v[active_r] && !exc_v[sel_nxt];
  end

  // selector state and status pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r         <= MODE_FREERUN;
      active_r       <= 2'b00;
      active_input   <= 2'b00;
      tracking       <= 1'b0;
      holdover       <= 1'b0;
      hitless_absorb <= 1'b0;
      pull_in        <= 1'b0;
    end else begin
      mode_r         <= mode_nxt;
      active_r       <= sel_nxt;
      active_input   <= sel_nxt;
      tracking       <= (mode_nxt == MODE_TRACK);
      holdover       <= (mode_nxt == MODE_HOLDOVER);
      hitless_absorb <= switch_w && hitless_ok;
      pull_in        <= switch_w && !hitless_ok;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outputs_enable    <= 1'b0;
      unlocked_flag_pin <= 1'b1;
    end else begin
      outputs_enable    <= !(ref_abs && !ctrl_r.keep_outputs);
      unlocked_flag_pin <= unlocked_w;
    end
  end

  always_comb begin
    live_w                     = '0;
    live_w[FLG_ABS +: 4]       = abs_v;
    live_w[FLG_REFABS]         = ref_abs;
    live_w[FLG_EXC +: 4]       = exc_v;
    live_w[FLG_LOL]            = unlocked_w;
    live_w[FLG_HOLD]           = holdover;
    w1c_w                      = '0;
    if (wr_do && wr_addr_r == OFS_STICKY) begin
      w1c_w = hwdata[FLAG_W-1:0];
    end
    sticky_nxt = ((sticky_r & ~w1c_w) | live_w) & FLAG_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sticky_r      <= '0;
      interrupt_pin <= 1'b0;
    end else begin
      sticky_r      <= sticky_nxt;
      interrupt_pin <= |(sticky_nxt & ~mask_r);
    end
  end

  // bus handshake; writes get one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (wr_pend_r) begin
      wr_pend_r <= 1'b0;
      hreadyout <= 1'b1;
    end else if (addr_ph && hwrite) begin
      wr_pend_r <= 1'b1;
      wr_addr_r <= {haddr[31:2], 2'b00};
      hreadyout <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= ismon_ctrl_t'(CTRL_RST);
      prio_r    <= PRIO_RST;
      sens_r    <= SENS_RST;
      oof_r     <= OOF_RST;
      lol_set_r <= LOL_SET_RST;
      lol_clr_r <= LOL_CLR_RST;
      lol_dly_r <= LOL_DLY_RST;
      mask_r    <= MASK_RST;
      mondis_r  <= MONDIS_RST;
    end else if (wr_do) begin
      if (wr_addr_r == OFS_CTRL) begin
        ctrl_r <= ismon_ctrl_t'(hwdata[CTRL_W-1:0]);
      end else if (wr_addr_r == OFS_PRIO) begin
        prio_r <= hwdata[7:0];
      end else if (wr_addr_r == OFS_SENS) begin
        sens_r <= hwdata;
      end else if (wr_addr_r == OFS_OOF) begin
        oof_r <= hwdata[15:0];
      end else if (wr_addr_r == OFS_LOL_SET) begin
        lol_set_r <= hwdata[LOL_W-1:0];
      end else if (wr_addr_r == OFS_LOL_CLR) begin
        lol_clr_r <= hwdata[LOL_W-1:0];
      end else if (wr_addr_r == OFS_LOL_DLY) begin
        lol_dly_r <= hwdata[DLY_W-1:0];
      end else if (wr_addr_r == OFS_MASK) begin
        mask_r <= hwdata[FLAG_W-1:0];
      end else if (wr_addr_r == OFS_MONDIS) begin
        mondis_r <= hwdata[4:0];
      end
    end
  end

  // read data captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ph && !hwrite && !wr_pend_r) begin
      hrdata <= 32'h0000_0000;
      if ({haddr[31:2], 2'b00} == OFS_CTRL) begin
        hrdata[CTRL_W-1:0] <= ctrl_r;
      end else if ({haddr[31:2], 2'b00} == OFS_PRIO) begin
        hrdata[7:0] <= prio_r;
      end else if ({haddr[31:2], 2'b00} == OFS_SENS) begin
        hrdata <= sens_r;
      end else if ({haddr[31:2], 2'b00} == OFS_OOF) begin
        hrdata[15:0] <= oof_r;
      end else if ({haddr[31:2], 2'b00} == OFS_LOL_SET) begin
        hrdata[LOL_W-1:0] <= lol_set_r;
      end else if ({haddr[31:2], 2'b00} == OFS_LOL_CLR) begin
        hrdata[LOL_W-1:0] <= lol_clr_r;
      end else if ({haddr[31:2], 2'b00} == OFS_LOL_DLY) begin
        hrdata[DLY_W-1:0] <= lol_dly_r;
      end else if ({haddr[31:2], 2'b00} == OFS_LIVE) begin
        hrdata[FLAG_W-1:0]         <= live_w & FLAG_MASK;
        hrdata[FLG_SEL +: 2]       <= active_r;
        hrdata[FLG_TRACK]          <= (mode_r == MODE_TRACK);
      end else if ({haddr[31:2], 2'b00} == OFS_STICKY) begin
        hrdata[FLAG_W-1:0] <= sticky_r;
      end else if ({haddr[31:2], 2'b00} == OFS_MASK) begin
        hrdata[FLAG_W-1:0] <= mask_r;
      end else if ({haddr[31:2], 2'b00} == OFS_MONDIS) begin
        hrdata[4:0] <= mondis_r;
      end
    end
  end
endmodule

// *** hdl/ismon_lock_mon.sv ***
// lock monitor with set and clear thresholds and clear delay
`timescale 1ns/1ps
module ismon_lock_mon
  import ismon_pkg::*;
(
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // phase detector difference and control
  input  wire logic [LOL_W-1:0] pd_diff,
  input  wire logic [LOL_W-1:0] set_thr,
  input  wire logic [LOL_W-1:0] clr_thr,
  input  wire logic [DLY_W-1:0] dly,
  input  wire logic             force_unlock,
  // status
  output logic                  unlocked_r
);
  logic [DLY_W-1:0] timer_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unlocked_r <= 1'b1;
      timer_r    <= '0;
    end else if (force_unlock || pd_diff > set_thr) begin
      unlocked_r <= 1'b1;
      timer_r    <= '0;
    end else if (unlocked_r && pd_diff < clr_thr) begin
      if (timer_r >= dly) begin
        unlocked_r <= 1'b0;
      end else begin
        timer_r <= timer_r + 1'b1;
      end
    end else begin
      timer_r <= '0;
    end
  end
endmodule

// *** hdl/ismon_pkg.sv ***
// constants, register map and carrier types of the input select and fault monitor
package ismon_pkg;
  // register byte offsets
  localparam logic [31:0] OFS_CTRL    = 32'h0000_0000;
  localparam logic [31:0] OFS_PRIO    = 32'h0000_0004;
  localparam logic [31:0] OFS_SENS    = 32'h0000_0008;
  localparam logic [31:0] OFS_OOF     = 32'h0000_000C;
  localparam logic [31:0] OFS_LOL_SET = 32'h0000_0010;
  localparam logic [31:0] OFS_LOL_CLR = 32'h0000_0014;
  localparam logic [31:0] OFS_LOL_DLY = 32'h0000_0018;
  localparam logic [31:0] OFS_LIVE    = 32'h0000_001C;
  localparam logic [31:0] OFS_STICKY  = 32'h0000_0020;
  localparam logic [31:0] OFS_MASK    = 32'h0000_0024;
  localparam logic [31:0] OFS_MONDIS  = 32'h0000_0028;
  // widths
  localparam int unsigned CTRL_W = 13;
  localparam int unsigned FLAG_W = 18;
  localparam int unsigned LOL_W  = 17;
  localparam int unsigned DLY_W  = 24;
  localparam int unsigned CNT_W  = 20;
  localparam int unsigned LIM_W  = 14;
  // flag vector field positions
  localparam int unsigned FLG_ABS    = 0;
  localparam int unsigned FLG_REFABS = 4;
  localparam int unsigned FLG_EXC    = 8;
  localparam int unsigned FLG_LOL    = 16;
  localparam int unsigned FLG_HOLD   = 17;
  localparam int unsigned FLG_SEL    = 20;
  localparam int unsigned FLG_TRACK  = 22;
  localparam logic [FLAG_W-1:0] FLAG_MASK = 18'h30F1F;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST    = 13'h0060;
  localparam logic [7:0]        PRIO_RST    = 8'hE4;
  localparam logic [31:0]       SENS_RST    = 32'h0101_0101;
  localparam logic [15:0]       OOF_RST     = 16'h0103;
  localparam logic [LOL_W-1:0]  LOL_SET_RST = 17'h0000A;
  localparam logic [LOL_W-1:0]  LOL_CLR_RST = 17'h00001;
  localparam logic [DLY_W-1:0]  LOL_DLY_RST = 24'h000000;
  localparam logic [FLAG_W-1:0] MASK_RST    = 18'h3FFFF;
  localparam logic [4:0]        MONDIS_RST  = 5'h00;
  // timing and scaling
  localparam logic [LIM_W-1:0] REF_ABS_LIMIT = 14'h0040;
  localparam int unsigned SENS_SHIFT = 6;
  localparam longint unsigned FAST_PPM  = 4000;
  localparam longint unsigned PPM_SCALE = 1000000;
  localparam int unsigned GATE_DEF = 500000;
  // control register fields, lsb last
  typedef struct packed {
    logic       prec_dis;
    logic       fast_dis;
    logic [2:0] oof_ref;
    logic       keep_outputs;
    logic       hitless_en;
    logic       revertive;
    logic       auto_en;
    logic       zero_delay;
    logic [1:0] reg_sel;
    logic       reg_sel_en;
  } ismon_ctrl_t;
  // selector modes
  typedef enum logic [1:0] {MODE_FREERUN, MODE_TRACK, MODE_HOLDOVER} ismon_mode_t;
endpackage
